// ### design/fsr_ctrl.sv
// host-side controller issuing flash commands and polling write status over the pins
`timescale 1ns/1ps
module fsr_ctrl (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // axi4-lite write
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [7:0] s_awaddr_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  output logic [1:0] s_bresp_out,
  // axi4-lite read
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  input wire logic [7:0] s_araddr_in,
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  output fsr_pkg::fsr_rsp_t s_r_out,
  // flash pins
  output fsr_pkg::fsr_pins_t flash_out,
  input wire logic [7:0] dq_in
);
  import fsr_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_WSET = 7'b0000010,
    ST_WSTB = 7'b0000100,
    ST_RSET = 7'b0001000,
    ST_RSTB = 7'b0010000,
    ST_EVAL = 7'b0100000,
    ST_DONE = 7'b1000000
  } fsr_state_t;

  fsr_state_t state_reg;
  logic [7:0] dq_s1_reg, dq_s2_reg;
  logic [2:0] op_reg;
  logic [18:0] addr_reg;
  logic [7:0] data_reg;
  logic [2:0] step_reg;
  logic [7:0] cnt_reg;
  logic [7:0] prev_reg, last_reg;
  logic first_reg, recheck_reg, busy_reg;
  logic [1:0] result_reg;
  logic [18:0] cyc_addr;
  logic [7:0] cyc_data;
  logic [2:0] nsteps;
  logic wr_go, w_ok, r_ok;

  // two-stage synchroniser; the flash drives asynchronously to our clock
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  // command table: each operation other than read is a list of write cycles
  always_comb begin
    cyc_addr = FSR_UNL1_ADDR;
    cyc_data = FSR_UNL1_DATA;
    case (op_reg)
      FSR_OP_PROG: nsteps = 3'd4;
      FSR_OP_CHIP, FSR_OP_SECT: nsteps = 3'd6;
      default: nsteps = 3'd1;
    endcase
    case (step_reg)
      3'd1, 3'd4: begin
        cyc_addr = FSR_UNL2_ADDR;
        cyc_data = FSR_UNL2_DATA;
      end
      3'd2: cyc_data = (op_reg == FSR_OP_PROG) ? FSR_CMD_PROG : FSR_CMD_ESET;
      3'd3: begin
        cyc_addr = (op_reg == FSR_OP_PROG) ? addr_reg : FSR_UNL1_ADDR;
        cyc_data = (op_reg == FSR_OP_PROG) ? data_reg : FSR_UNL1_DATA;
      end
      3'd5: begin
        cyc_addr = (op_reg == FSR_OP_SECT) ? addr_reg : FSR_UNL1_ADDR;
        cyc_data = (op_reg == FSR_OP_SECT) ? FSR_CMD_SECT : FSR_CMD_CHIP;
      end
      default: begin
        case (op_reg)
          FSR_OP_SUSP: cyc_data = FSR_CMD_SUSP;
          FSR_OP_RESM: cyc_data = FSR_CMD_SECT;
          FSR_OP_RST: cyc_data = FSR_CMD_RST;
          default: ;
        endcase
      end
    endcase
  end

  // axi-lite handshakes: write needs both channels, one transfer at a time
  assign w_ok = s_awvalid_in && s_wvalid_in && !s_bvalid_out;
  assign s_awready_out = w_ok;
  assign s_wready_out = w_ok;
  assign r_ok = s_arvalid_in && !s_rvalid_out;
  assign s_arready_out = r_ok;
  assign wr_go = w_ok && (s_awaddr_in == FSR_CTRL_OFS) && s_wstrb_in[0] && s_wdata_in[FSR_CTRL_GO_POS]
                 && !busy_reg;

  // software-written operands; busy guards against changes mid-sequence
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_reg <= FSR_ZERO_RST[18:0];
      data_reg <= FSR_ZERO_RST[7:0];
      op_reg <= FSR_ZERO_RST[2:0];
    end else if (w_ok && !busy_reg) begin
      if (s_awaddr_in == FSR_ADDR_OFS)
        addr_reg <= s_wdata_in[18:0];
      if (s_awaddr_in == FSR_DATA_OFS && s_wstrb_in[0])
        data_reg <= s_wdata_in[7:0];
      if (wr_go)
        op_reg <= s_wdata_in[FSR_CTRL_OP_LSB +: 3];
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_bvalid_out <= 1'b0;
      s_bresp_out <= 2'h0;
    end else if (w_ok) begin
      s_bvalid_out <= 1'b1;
      s_bresp_out <= (s_awaddr_in > FSR_LAST_OFS || s_awaddr_in[1:0] != 2'h0) ? 2'h2 : 2'h0;
    end else if (s_bready_in) begin
      s_bvalid_out <= 1'b0;
    end
  end

  // read data, one cycle after the address is taken
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_rvalid_out <= 1'b0;
      s_r_out <= '0;
    end else if (r_ok) begin
      s_rvalid_out <= 1'b1;
      s_r_out.resp <= 2'h0;
      case (s_araddr_in)
        FSR_CTRL_OFS: s_r_out.data <= {28'h0000000, op_reg, busy_reg};
        FSR_ADDR_OFS: s_r_out.data <= {13'h0000, addr_reg};
        FSR_DATA_OFS: s_r_out.data <= {24'h000000, data_reg};
        FSR_STAT_OFS: s_r_out.data <= {29'h00000000, recheck_reg, result_reg};
        FSR_LAST_OFS: s_r_out.data <= {24'h000000, last_reg};
        default: begin
          s_r_out.data <= 32'h0000_0000;
          s_r_out.resp <= 2'h2;
        end
      endcase
    end else if (s_rready_in) begin
      s_rvalid_out <= 1'b0;
    end
  end

  // sequencer: write cycles, then toggle polling until the byte settles
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ST_IDLE;
      step_reg <= 3'd0;
      cnt_reg <= 8'h00;
      prev_reg <= 8'h00;
      last_reg <= 8'h00;
      first_reg <= 1'b0;
      recheck_reg <= 1'b0;
      busy_reg <= 1'b0;
      result_reg <= FSR_RES_NONE;
      flash_out <= {19'h00000, 1'b1, 1'b1, 1'b1, 8'h00, 1'b1};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (wr_go) begin
            busy_reg <= 1'b1;
            step_reg <= 3'd0;
            first_reg <= 1'b1;
            recheck_reg <= 1'b0;
            result_reg <= FSR_RES_NONE;
            state_reg <= (s_wdata_in[FSR_CTRL_OP_LSB +: 3] == FSR_OP_READ) ? ST_RSET : ST_WSET;
          end
        end
        ST_WSET: begin
          flash_out.addr <= cyc_addr;
          flash_out.dq <= cyc_data;
          flash_out.dq_oe_n <= 1'b0;
          flash_out.ce_n <= 1'b0;
          flash_out.we_n <= 1'b0;
          cnt_reg <= FSR_PULSE_CYC;
          state_reg <= ST_WSTB;
        end
        ST_WSTB: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            // rising strobe edge latches data; final edge starts status reporting
            flash_out.we_n <= 1'b1;
            flash_out.ce_n <= 1'b1;
            flash_out.dq_oe_n <= 1'b1;
            if (step_reg == nsteps - 3'd1) begin
              // suspend, resume and reset need no polling
              state_reg <= (op_reg == FSR_OP_PROG || op_reg == FSR_OP_CHIP || op_reg == FSR_OP_SECT)
                           ? ST_RSET : ST_DONE;
              if (op_reg == FSR_OP_RST)
                result_reg <= FSR_RES_OK;
            end else begin
              step_reg <= step_reg + 3'd1;
              state_reg <= ST_WSET;
            end
          end
        end
        ST_RSET: begin
          // each read is a fresh oe/ce cycle so the toggle bit can advance
          flash_out.addr <= addr_reg;
          flash_out.ce_n <= 1'b0;
          flash_out.oe_n <= 1'b0;
          cnt_reg <= FSR_PULSE_CYC + 8'd2; // covers the two synchroniser stages
          state_reg <= ST_RSTB;
        end
        ST_RSTB: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            flash_out.oe_n <= 1'b1;
            flash_out.ce_n <= 1'b1;
            prev_reg <= last_reg; // older read kept so the toggle compare sees two distinct reads
            last_reg <= dq_s2_reg; // whole byte kept, poll bit alone is not trusted
            state_reg <= (op_reg == FSR_OP_READ) ? ST_DONE : ST_EVAL;
          end
        end
        ST_EVAL: begin
          // compare toggle bits of two back-to-back reads of the full byte
          first_reg <= 1'b0;
          if (first_reg) begin
            state_reg <= ST_RSET;
          end else if (prev_reg[FSR_TOGL_BIT] == last_reg[FSR_TOGL_BIT]) begin
            result_reg <= FSR_RES_OK;
            state_reg <= ST_DONE;
          end else if (recheck_reg) begin
            result_reg <= FSR_RES_FAIL;
            state_reg <= ST_DONE;
          end else begin
            // error bit seen while toggling: one more read, compared with this one, decides
            recheck_reg <= last_reg[FSR_TOUT_BIT];
            state_reg <= ST_RSET;
          end
        end
        ST_DONE: begin
          busy_reg <= 1'b0;
          step_reg <= 3'd0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // upper strobe lanes are ignored; the address register takes bits 18:0 whatever the strobes, every other field sits in byte lane 0
  logic unused_ok;
  assign unused_ok = ^s_wstrb_in[3:1];
endmodule

// ### design/fsr_pkg.sv
// package for the flash write status controller: constants, types and register map
// Functional notes
// - host polls at an address inside the unprotected sector being worked on
// - after timeout error host issues reset command; the controller only reports the failure, software must start the reset job
// - host reads full byte twice and compares toggle bit
// - toggling with timeout error set: recheck, still toggling means failure
// - after pausing monitoring host restarts toggle check from first step
package fsr_pkg;
  // software register byte offsets
  localparam logic [7:0] FSR_CTRL_OFS = 8'h00;
  localparam logic [7:0] FSR_ADDR_OFS = 8'h04;
  localparam logic [7:0] FSR_DATA_OFS = 8'h08;
  localparam logic [7:0] FSR_STAT_OFS = 8'h0C;
  localparam logic [7:0] FSR_LAST_OFS = 8'h10;
  // control field positions and operation codes
  localparam int FSR_CTRL_GO_POS = 0;
  localparam int FSR_CTRL_OP_LSB = 1;
  localparam logic [2:0] FSR_OP_PROG = 3'h0;
  localparam logic [2:0] FSR_OP_CHIP = 3'h1;
  localparam logic [2:0] FSR_OP_SECT = 3'h2;
  localparam logic [2:0] FSR_OP_SUSP = 3'h3;
  localparam logic [2:0] FSR_OP_RESM = 3'h4;
  localparam logic [2:0] FSR_OP_RST = 3'h5;
  localparam logic [2:0] FSR_OP_READ = 3'h6;
  // status byte bit positions
  localparam int FSR_POLL_BIT = 7;
  localparam int FSR_TOGL_BIT = 6;
  localparam int FSR_TOUT_BIT = 5;
  localparam int FSR_ESTG_BIT = 2;
  // command bytes and unlock addresses
  localparam logic [18:0] FSR_UNL1_ADDR = 19'h00555;
  localparam logic [18:0] FSR_UNL2_ADDR = 19'h002AA;
  localparam logic [7:0] FSR_UNL1_DATA = 8'hAA;
  localparam logic [7:0] FSR_UNL2_DATA = 8'h55;
  localparam logic [7:0] FSR_CMD_PROG = 8'hA0;
  localparam logic [7:0] FSR_CMD_ESET = 8'h80;
  localparam logic [7:0] FSR_CMD_CHIP = 8'h10;
  localparam logic [7:0] FSR_CMD_SECT = 8'h30;
  localparam logic [7:0] FSR_CMD_SUSP = 8'hB0;
  localparam logic [7:0] FSR_CMD_RST = 8'hF0;
  // bus cycle timing
  localparam int FSR_CLK_MHZ = 250;
  localparam int FSR_PULSE_NS = 100;
  localparam logic [7:0] FSR_PULSE_CYC = 8'((FSR_PULSE_NS * FSR_CLK_MHZ + 999) / 1000);
  // reset values
  localparam logic [31:0] FSR_ZERO_RST = 32'h0000_0000;
  // outcome codes
  localparam logic [1:0] FSR_RES_NONE = 2'h0;
  localparam logic [1:0] FSR_RES_OK = 2'h1;
  localparam logic [1:0] FSR_RES_FAIL = 2'h2;
  // pin group toward the flash
  typedef struct packed {
    logic [18:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [7:0] dq;
    logic dq_oe_n;
  } fsr_pins_t;
  // axi-lite response pair
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } fsr_rsp_t;
endpackage

// ### verification/fsr_ctrl_monitor.sv
// assertion checker watching the controller's ports
`timescale 1ns/1ps
module fsr_ctrl_monitor (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // axi4-lite
  input wire logic s_awvalid_in,
  input wire logic s_awready_out,
  input wire logic [7:0] s_awaddr_in,
  input wire logic s_wvalid_in,
  input wire logic s_wready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [1:0] s_bresp_out,
  input wire logic s_arvalid_in,
  input wire logic s_arready_out,
  input wire logic [7:0] s_araddr_in,
  input wire logic s_rvalid_out,
  input wire logic s_rready_in,
  input fsr_pkg::fsr_rsp_t s_r_out,
  // flash pins
  input fsr_pkg::fsr_pins_t flash_out,
  input wire logic [7:0] dq_in
);
  import fsr_pkg::*;
  logic [7:0] we_cnt_reg;
  logic [7:0] rd_cnt_reg;
  // strobe lengths counted so a pulse is judged when it ends
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      we_cnt_reg <= 8'h00;
      rd_cnt_reg <= 8'h00;
    end else begin
      we_cnt_reg <= flash_out.we_n ? 8'h00 : we_cnt_reg + 8'h01;
      rd_cnt_reg <= flash_out.oe_n ? 8'h00 : rd_cnt_reg + 8'h01;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_wr_answer; s_awvalid_in && s_wvalid_in && !s_bvalid_out |=> s_bvalid_out; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_hold; s_bvalid_out && !s_bready_in |=> s_bvalid_out && $stable(s_bresp_out); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_answer; s_arvalid_in && !s_rvalid_out |=> s_rvalid_out; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_unmapped; s_arvalid_in && !s_rvalid_out && s_araddr_in > FSR_LAST_OFS |=> s_r_out.resp == 2'h2; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_we_width; $rose(flash_out.we_n) |-> we_cnt_reg == FSR_PULSE_CYC + 8'h01; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe length wrong");
  // read strobe covers the pulse, the two synchroniser stages and the launch cycle
  property p_rd_width; $rose(flash_out.oe_n) |-> rd_cnt_reg == FSR_PULSE_CYC + 8'h03; endproperty
  a_rd_width: assert property (p_rd_width) else $error("read strobe length wrong");
  property p_wr_drive; !flash_out.we_n |-> flash_out.oe_n && !flash_out.ce_n && !flash_out.dq_oe_n; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write cycle malformed");
  property p_rd_steady; !flash_out.oe_n && !$fell(flash_out.oe_n) |-> flash_out.dq_oe_n && $stable(flash_out.addr); endproperty
  a_rd_steady: assert property (p_rd_steady) else $error("read cycle malformed");
endmodule
bind fsr_ctrl fsr_ctrl_monitor i_mon (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .s_awvalid_in(s_awvalid_in), .s_awready_out(s_awready_out), .s_awaddr_in(s_awaddr_in),
  .s_wvalid_in(s_wvalid_in), .s_wready_out(s_wready_out), .s_wdata_in(s_wdata_in), .s_wstrb_in(s_wstrb_in),
  .s_bvalid_out(s_bvalid_out), .s_bready_in(s_bready_in), .s_bresp_out(s_bresp_out),
  .s_arvalid_in(s_arvalid_in), .s_arready_out(s_arready_out), .s_araddr_in(s_araddr_in),
  .s_rvalid_out(s_rvalid_out), .s_rready_in(s_rready_in), .s_r_out(s_r_out), .flash_out(flash_out), .dq_in(dq_in));

// ### verification/fsr_flash_model.sv
// behavioural flash device reporting program and erase status
`timescale 1ns/1ps
module fsr_flash_model (
  // pins from the controller
  input fsr_pkg::fsr_pins_t pins_in,
  // bench controls
  input wire logic [3:0] busy_in,
  input wire logic fail_in,
  input wire logic prot_in,
  // data lines toward the controller
  output logic [7:0] dq_out
);
  import fsr_pkg::*;
  logic [7:0] arr = 8'hFF, pd = 8'h00, rd_val = 8'h00, last_cmd = 8'h00;
  logic [18:0] pa = 19'h00000;
  logic busy = 1'b0, erase = 1'b0, tog = 1'b0, etg = 1'b0, tout = 1'b0, armed = 1'b0, eset = 1'b0, prot = 1'b0;
  int left = 0, bad_poll = 0;
  realtime t0 = 0.0;
  // commands taken at the rising write strobe; busy blocks new jobs but still takes reset and the program and erase-setup arm codes
  // program data is taken before the reset check, so a data byte equal to the reset code still programs
  always @(posedge pins_in.we_n) begin
    last_cmd = pins_in.dq;
    if (!busy && armed) begin
      {pa, pd, busy, erase, armed} = {pins_in.addr, pins_in.dq, 3'b100};
      left = busy_in + 1;
      prot = prot_in;
      t0 = $realtime;
    end else if (pins_in.dq == FSR_CMD_RST) {busy, tout, armed, eset} = 4'h0;
    else if (!busy && eset && pins_in.dq inside {FSR_CMD_CHIP, FSR_CMD_SECT}) begin
      {pa, busy, erase, eset} = {pins_in.addr, 3'b110};
      left = busy_in + 1;
      prot = prot_in;
      t0 = $realtime;
    end else if (pins_in.dq == FSR_CMD_PROG) armed = 1'b1;
    else if (pins_in.dq == FSR_CMD_ESET) eset = 1'b1;
  end
  // each read start while busy advances the toggle bit, and the erase toggle bit during erases; a failed job runs until a reset command
  always @(negedge pins_in.oe_n) begin
    if (busy) begin
      if (!erase && pins_in.addr != pa) bad_poll++;
      tog = ~tog;
      etg = erase ? ~etg : etg;
      rd_val = {erase ? 1'b0 : ~pd[7], tog, tout, 2'b00, etg, 2'b00};
      left--;
      if (prot) begin
        // protected target: toggles for a while, then back to read with the array untouched
        busy = ($realtime - t0) < (erase ? 100000.0 : 2000.0);
      end else if (left <= 0 && fail_in) begin
        tout = 1'b1;
      end else if (left <= 0) begin
        {busy, arr} = {1'b0, erase ? 8'hFF : pd};
        // poll bit turns valid on this read while the lower bits still show status
        rd_val[7] = arr[7];
      end
    end else rd_val = arr;
  end
  // released lines show the inverse so a stale byte is never mistaken
  assign dq_out = (pins_in.oe_n || pins_in.ce_n) ? ~rd_val : rd_val;
endmodule

// ### verification/test_fsr_ctrl.sv
// self-checking bench driving the controller over axi4-lite against the flash model
`timescale 1ns/1ps
module test_fsr_ctrl;
  import fsr_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, fail = 1'b0, prot = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, dq_dev, dq_wire, d;
  logic [31:0] wdata = 32'h0, rdata, stat, last;
  logic [18:0] a;
  logic [3:0] busy = 4'h0;
  logic [1:0] bresp, rresp, wresp;
  fsr_rsp_t r_out;
  fsr_pins_t pins;
  int n_mismatch = 0, tests_run = 0;
  // shared data lines: whoever enables drives them
  assign dq_wire = pins.dq_oe_n ? dq_dev : pins.dq;
  always #2 core_clk = ~core_clk;
  fsr_ctrl i_dut (.core_clk_in(core_clk), .arst_n_in(arst_n), .s_awvalid_in(awvalid), .s_awready_out(awready),
    .s_awaddr_in(awaddr), .s_wvalid_in(wvalid), .s_wready_out(wready), .s_wdata_in(wdata), .s_wstrb_in(4'hF),
    .s_bvalid_out(bvalid), .s_bready_in(bready), .s_bresp_out(bresp), .s_arvalid_in(arvalid),
    .s_arready_out(arready), .s_araddr_in(araddr), .s_rvalid_out(rvalid), .s_rready_in(rready),
    .s_r_out(r_out), .flash_out(pins), .dq_in(dq_wire));
  fsr_flash_model i_flash (.pins_in(pins), .busy_in(busy), .fail_in(fail), .prot_in(prot), .dq_out(dq_dev));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected status word: recheck flag above the two-bit outcome
  function automatic logic [31:0] exp_stat(input logic recheck, input logic [1:0] res);
    return {29'h0, recheck, res};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {ad, dt, 3'b111};
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    @(posedge core_clk);
    {araddr, arvalid, rready} <= {ad, 2'b11};
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    {rdata, rresp} = r_out;
    rready <= 1'b0;
  endtask
  // one flash job; an address write while busy must be ignored
  task automatic run_op(input logic [2:0] op);
    axi_wr(FSR_ADDR_OFS, {13'h0, a});
    axi_wr(FSR_DATA_OFS, {24'h0, d});
    axi_wr(FSR_CTRL_OFS, {28'h0, op, 1'b1});
    axi_wr(FSR_ADDR_OFS, {13'h0, ~a});
    do axi_rd(FSR_CTRL_OFS); while (rdata[0] !== 1'b0);
    axi_rd(FSR_STAT_OFS);
    stat = rdata;
    axi_rd(FSR_LAST_OFS);
    last = rdata;
    axi_rd(FSR_ADDR_OFS);
    check("addr", rdata, {13'h0, a});
  endtask
  // main sequence: register defaults, programs, failure, reset, erases
  initial begin
    void'($urandom(32706));
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(i * 4));
      check("reg", rdata, FSR_ZERO_RST);
      check("rresp", rresp, (i == 5) ? 2'h2 : 2'h0);
    end
    axi_wr(8'h14, 32'h1);
    check("bresp", wresp, 2'h2);
    for (int i = 0; i < 5; i++) begin
      a = 19'($urandom);
      d = (i == 0) ? 8'h20 : 8'($urandom);
      busy <= (i == 0) ? 4'h0 : 4'($urandom % 8);
      run_op(FSR_OP_PROG);
      // the recheck flag depends on bit 5 of the programmed byte, so it is masked here
      check("stat", stat & 32'hFFFF_FFFB, exp_stat(1'b0, FSR_RES_OK));
      check("last", last, d);
      check("pa", i_flash.pa, a);
    end
    fail <= 1'b1;
    run_op(FSR_OP_PROG);
    check("fail", stat, exp_stat(1'b1, FSR_RES_FAIL));
    fail <= 1'b0;
    run_op(FSR_OP_RST);
    check("rst", stat, exp_stat(1'b0, FSR_RES_OK));
    check("tout", i_flash.tout, 1'b0);
    run_op(FSR_OP_READ);
    check("kept", last, d);
    // protected target: toggling stops on its own and the old byte stays
    prot <= 1'b1;
    d = ~d;
    run_op(FSR_OP_PROG);
    prot <= 1'b0;
    check("protect stat", stat & 32'hFFFF_FFFB, exp_stat(1'b0, FSR_RES_OK));
    check("protect", last, {24'h0, ~d});
    for (int i = 0; i < 2; i++) begin
      run_op(i ? FSR_OP_SECT : FSR_OP_CHIP);
      check("erase", stat[1:0], FSR_RES_OK);
      check("blank", last, 8'hFF);
    end
    // suspend and resume are single command writes with no polling behind them
    for (int i = 0; i < 2; i++) begin
      run_op(i ? FSR_OP_RESM : FSR_OP_SUSP);
      check("cmd", i_flash.last_cmd, i ? FSR_CMD_SECT : FSR_CMD_SUSP);
      check("nopoll", stat, exp_stat(1'b0, FSR_RES_NONE));
    end
    check("poll", i_flash.bad_poll, 0);
    report_and_stop();
  end
  // watchdog well beyond the expected run length
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
